// >>> fq_pkg.sv
package fq_pkg;
  // System clock period and the derived cycles per microsecond.
  localparam int CLK_PERIOD_NS = 8;
  localparam int US_NS         = 1000;
  localparam int US_CYCLES     = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // 10 MHz synthesis: add TEN_STEP per clock, toggle on passing TEN_MOD.
  localparam logic [5:0] TEN_STEP = 6'h04;
  localparam logic [5:0] TEN_MOD  = 6'h19;

  // The 50 kHz phase reference toggles every REF50_HALF_US microseconds.
  localparam logic [3:0] REF50_HALF_US = 4'ha;

  // Register byte addresses.
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CNT_A  = 8'h08;
  localparam logic [7:0] ADDR_CNT_B  = 8'h0c;
  localparam logic [7:0] ADDR_SYNTH  = 8'h10;
  localparam logic [7:0] ADDR_DELAY  = 8'h14;

  // Control register fields.
  localparam int CTRL_GO     = 0;
  localparam int CTRL_PRS    = 1;
  localparam int CTRL_SWEEP  = 2;
  localparam int CTRL_LONG   = 3;
  localparam int CTRL_GSEL   = 4;
  localparam int CTRL_DIRECT = 7;

  // Status register fields.
  localparam int ST_BUSY   = 0;
  localparam int ST_DONE   = 1;
  localparam int ST_WIDE   = 2;
  localparam int ST_NARROW = 3;
  localparam int ST_HIT    = 4;
  localparam int ST_SEARCH = 5;

  // Divider bounds: 300 MHz and 350 MHz over 50 kHz, 100 kHz steps.
  localparam logic [12:0] N_MIN  = 13'h1770;
  localparam logic [12:0] N_MAX  = 13'h1b58;
  localparam logic [12:0] N_STEP = 13'h0002;

  // Gate select reaches 1 s at code six.
  localparam logic [2:0] GSEL_MAX = 3'h6;

  // Sequence lengths and sweep step time in microseconds; sweep length in milliseconds.
  localparam int PRS_SHORT_US_DEF = 360400;
  localparam int PRS_LONG_US_DEF  = 2096000;
  localparam int SWEEP_MS         = 90;
  localparam int SWEEP_STEPS      = (N_MAX - N_MIN) / N_STEP;
  localparam int SWEEP_STEP_US_DEF = SWEEP_MS * 1000 / SWEEP_STEPS;

  // Reset values.
  localparam logic [21:0] DELAY_RST = 22'h00_0000;
  localparam logic [15:0] LFSR_SEED = 16'hace1;

  // Measurement sequencer states.
  typedef enum logic [2:0] {
    S_IDLE, S_GATE, S_PRS, S_DELAY, S_SWEEP
  } meas_state_t;
endpackage

// >>> tb_if.sv
`timescale 1ns/10ps
// Time-base clocks and the microsecond tick shared with the sequencer.
interface tb_if;
  logic tick_us;  // One-cycle pulse each microsecond.
  logic clk10;    // 10 MHz logic clock.
  logic clk1m;    // 1 MHz logic clock.
  logic clk500k;  // 500 kHz logic clock.
  logic ref50k;   // 50 kHz phase reference.
  modport src (output tick_us, clk10, clk1m, clk500k, ref50k);
  modport dst (input tick_us, clk10, clk1m, clk500k, ref50k);
endinterface

// >>> timebase.sv
`timescale 1ns/10ps
module timebase #(
  parameter int unsigned US_CYCLES = fq_pkg::US_CYCLES
) (
  input wire logic pclk,     // System clock.
  input wire logic presetn,  // Asynchronous reset, active low.
  input wire logic clk_en,   // Freezes all state while low.
  tb_if.src        tb        // Derived clocks and tick.
);
  logic [15:0] div_cnt;       // Cycle count within a microsecond.
  logic [15:0] next_div_cnt;
  logic [5:0]  acc10;         // Fractional accumulator for 10 MHz.
  logic [5:0]  next_acc10;
  logic [5:0]  sum10;         // Accumulator after this clock's step.
  logic [3:0]  ref_cnt;       // Microseconds within a 50 kHz half period.
  logic [3:0]  next_ref_cnt;
  logic        next_tick;
  logic        next_c10;
  logic        next_c1m;
  logic        next_c500;
  logic        next_ref;

  // Next values; 125 MHz is no integer multiple of 10 MHz, so the
  // 10 MHz edges jitter by one clock while the mean rate is exact.
  always_comb
  begin
    next_tick    = (div_cnt == 16'(US_CYCLES - 1));
    next_div_cnt = next_tick ? 16'h0000 : div_cnt + 16'h0001;
    next_c1m     = (div_cnt < 16'(US_CYCLES / 2));
    next_c500    = next_tick ? ~tb.clk500k : tb.clk500k;
    sum10        = acc10 + fq_pkg::TEN_STEP;
    next_acc10   = sum10;
    next_c10     = tb.clk10;
    if (sum10 >= fq_pkg::TEN_MOD)
    begin
      next_acc10 = sum10 - fq_pkg::TEN_MOD;
      next_c10   = ~tb.clk10;
    end
    next_ref_cnt = ref_cnt;
    next_ref     = tb.ref50k;
    if (next_tick)
    begin
      if (ref_cnt == fq_pkg::REF50_HALF_US - 4'h1)
      begin
        next_ref_cnt = 4'h0;
        next_ref     = ~tb.ref50k;
      end
      else
      begin
        next_ref_cnt = ref_cnt + 4'h1;
      end
    end
  end

  // Registers only.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_cnt    <= 16'h0000;
      acc10      <= 6'h00;
      ref_cnt    <= 4'h0;
      tb.tick_us <= 1'b0;
      tb.clk10   <= 1'b0;
      tb.clk1m   <= 1'b0;
      tb.clk500k <= 1'b0;
      tb.ref50k  <= 1'b0;
    end
    else if (clk_en)
    begin
      div_cnt    <= next_div_cnt;
      acc10      <= next_acc10;
      ref_cnt    <= next_ref_cnt;
      tb.tick_us <= next_tick;
      tb.clk10   <= next_c10;
      tb.clk1m   <= next_c1m;
      tb.clk500k <= next_c500;
      tb.ref50k  <= next_ref;
    end
  end
endmodule // timebase

// >>> freq_counter_ctrl.sv
`timescale 1ns/10ps
// Function
// - Gate length follows resolution, opens only when enabled.
// - Counter A accumulates input counts only while gated or on sequence chips that select A.
// - Pollable end-of-delay flag; software restarts measurement with a new GO write.
// - Direct path used below 500 MHz.
// - Divider N equals frequency over 50 kHz.
// - Local frequency 300 to 350 MHz, 100 kHz steps.
// - Search steps downward from the current divider (350 MHz at reset) to 300 MHz, 90 ms.
// - Wide filter searching, narrow filter while counting.
// - Offset search enabled until 500 kHz detected.
// - Sweep halts when narrow IF flag true.
// - Wide IF flag latched over harmonic determination.
// - Gate times from 1 us to 1 s, decades.
// - Sequence length 360.4 ms or 2.096 s.
// - Logic clocks 10 MHz, 1 MHz, 500 kHz.
// - Counters A and B get equal time.
// - 1 Hz resolution uses a 1 s gate.
module freq_counter_ctrl #(
  parameter int unsigned PRS_SHORT_US  = fq_pkg::PRS_SHORT_US_DEF,
  parameter int unsigned PRS_LONG_US   = fq_pkg::PRS_LONG_US_DEF,
  parameter int unsigned SWEEP_STEP_US = fq_pkg::SWEEP_STEP_US_DEF,
  parameter int unsigned US_CYCLES     = fq_pkg::US_CYCLES
) (
  input  wire logic        pclk,        // System clock, 125 MHz.
  input  wire logic        presetn,     // Asynchronous reset, active low.
  input  wire logic        clk_en,      // Freezes all state while low.
  input  wire logic        psel,        // APB select.
  input  wire logic        penable,     // APB access phase.
  input  wire logic        pwrite,      // APB write direction.
  input  wire logic [7:0]  paddr,       // APB byte address.
  input  wire logic [31:0] pwdata,      // APB write data.
  output logic      [31:0] prdata,      // APB read data.
  output logic             pready,      // APB ready.
  output logic             pslverr,     // APB error, unmapped address.
  input  wire logic        count_in,    // Conditioned input count pin.
  input  wire logic        if_narrow,   // IF in 50-100 MHz range pin.
  input  wire logic        if_wide,     // IF in 25-125 MHz range pin.
  input  wire logic        diff_ok,     // 500 kHz difference detected pin.
  output logic             dir_gate,    // Direct-count main gate open.
  output logic             osc_sel,     // High selects offset osc/B.
  output logic             filter_wide, // High selects wide loop filter.
  output logic             offset_search_enable, // Offset search on.
  output logic             direct_path, // Direct-count path selected.
  output logic      [12:0] synth_n,     // Divide-by-N factor.
  output logic             clk_10m,     // 10 MHz logic clock.
  output logic             clk_1m,      // 1 MHz logic clock.
  output logic             clk_500k,    // 500 kHz logic clock.
  output logic             ref_50k      // 50 kHz phase reference.
);
  tb_if tbs ();  // Time-base signals from the divider block.

  // Time base derived from the system clock.
  // logic clocks generated
  timebase #(
    .US_CYCLES (US_CYCLES)
  ) u_timebase (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .tb      (tbs)
  );

  assign clk_10m  = tbs.clk10;
  assign clk_1m   = tbs.clk1m;
  assign clk_500k = tbs.clk500k;
  assign ref_50k  = tbs.ref50k;

  // Gate length in microseconds for a decade code; code six is one second.
  function automatic logic [21:0] decade_us(input logic [2:0] sel);
    logic [21:0] v;
    v = 22'h00_0001;
    for (int i = 0; i < 6; i++)
    begin
      if (3'(i) < sel)
      begin
        v = 22'(v * 22'h00_000a);
      end
    end
    return v;
  endfunction

  // Keep a requested divider inside range and on a 100 kHz step.
  function automatic logic [12:0] legal_n(input logic [12:0] v);
    logic [12:0] r;
    r = {v[12:1], 1'b0};
    if (r < fq_pkg::N_MIN)
    begin
      r = fq_pkg::N_MIN;
    end
    else if (r > fq_pkg::N_MAX)
    begin
      r = fq_pkg::N_MAX;
    end
    return r;
  endfunction

  // Pin synchronisers; stage one feeds stage two only.
  logic [3:0] pin_s1;     // First stage.
  logic [3:0] pin_s2;     // Second stage, safe to read.
  logic       count_prev; // Previous count level for edge detection.
  logic       count_edge; // One rising input edge.

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_s1     <= 4'h0;
      pin_s2     <= 4'h0;
      count_prev <= 1'b0;
    end
    else if (clk_en)
    begin
      pin_s1     <= {diff_ok, if_wide, if_narrow, count_in};
      pin_s2     <= pin_s1;
      count_prev <= pin_s2[0];
    end
  end

  assign count_edge = pin_s2[0] & ~count_prev;

  // Register file state.
  logic [2:0]  gate_sel;   // Decade gate code.
  logic        long_prs;   // Long sequence selected.
  logic [21:0] delay_us;   // Sample-rate delay length.
  logic [31:0] cnt_a;      // Counter A.
  logic [31:0] cnt_b;      // Counter B.
  logic        done;       // End of sample-rate delay.
  logic        wide_lat;   // Latched wide-range IF flag.
  logic        sweep_hit;  // Sweep stopped on the narrow flag.
  logic [21:0] us_cnt;     // Microseconds into the current phase.
  logic [15:0] lfsr;       // Sequence generator.
  logic        half;       // Second half of a sequence bit.
  fq_pkg::meas_state_t state;

  // Access decode; a write takes effect at the completing edge.
  logic access;
  logic wr_ctrl;
  logic wr_synth;
  logic wr_delay;
  assign access   = psel & penable & pready;
  assign wr_ctrl  = access & pwrite & (paddr == fq_pkg::ADDR_CTRL);
  assign wr_synth = access & pwrite & (paddr == fq_pkg::ADDR_SYNTH);
  assign wr_delay = access & pwrite & (paddr == fq_pkg::ADDR_DELAY);

  // Next values of the bus answer.
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic        mapped;

  // One wait state: ready rises in the second access cycle, so the read
  // data is registered from a stable address.
  always_comb
  begin
    next_pready  = psel & penable & ~pready;
    next_prdata  = prdata;
    next_pslverr = 1'b0;
    mapped       = 1'b1;
    if (next_pready)
    begin
      next_prdata = 32'h0000_0000;
      case (paddr)
        fq_pkg::ADDR_CTRL:
        begin
          next_prdata[fq_pkg::CTRL_LONG] = long_prs;
          next_prdata[fq_pkg::CTRL_GSEL +: 3] = gate_sel;
          next_prdata[fq_pkg::CTRL_DIRECT] = direct_path;
        end
        fq_pkg::ADDR_STATUS:
        begin
          next_prdata[fq_pkg::ST_DONE] = done;
          next_prdata[fq_pkg::ST_BUSY] = (state != fq_pkg::S_IDLE);
          next_prdata[fq_pkg::ST_WIDE] = wide_lat;
          next_prdata[fq_pkg::ST_NARROW] = pin_s2[1];
          next_prdata[fq_pkg::ST_HIT] = sweep_hit;
          next_prdata[fq_pkg::ST_SEARCH] = offset_search_enable;
        end
        fq_pkg::ADDR_CNT_A: next_prdata = cnt_a;
        fq_pkg::ADDR_CNT_B: next_prdata = cnt_b;
        fq_pkg::ADDR_SYNTH: next_prdata = {19'h0_0000, synth_n};
        fq_pkg::ADDR_DELAY: next_prdata = {10'h000, delay_us};
        default:            mapped = 1'b0;
      endcase
      next_pslverr = ~mapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else if (clk_en)
    begin
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // Next values of the measurement sequencer.
  fq_pkg::meas_state_t next_state;
  logic [2:0]  next_gate_sel;
  logic        next_long_prs;
  logic        next_direct;
  logic [21:0] next_delay_us;
  logic [31:0] next_cnt_a;
  logic [31:0] next_cnt_b;
  logic        next_done;
  logic        next_wide_lat;
  logic        next_sweep_hit;
  logic [21:0] next_us_cnt;
  logic [15:0] next_lfsr;
  logic        next_half;
  logic [12:0] next_synth_n;
  logic        sel_b;      // Current sequence chip selects counter B.
  logic [21:0] us_inc;     // Microsecond count after this tick.
  logic [21:0] prs_len;    // Selected sequence length.

  always_comb
  begin
    next_state     = state;
    next_gate_sel  = gate_sel;
    next_long_prs  = long_prs;
    next_direct    = direct_path;
    next_delay_us  = delay_us;
    next_cnt_a     = cnt_a;
    next_cnt_b     = cnt_b;
    next_done      = done;
    next_wide_lat  = wide_lat;
    next_sweep_hit = sweep_hit;
    next_us_cnt    = us_cnt;
    next_lfsr      = lfsr;
    next_half      = half;
    next_synth_n   = synth_n;
    us_inc         = us_cnt + 22'h00_0001;
    prs_len = long_prs ? 22'(PRS_LONG_US) : 22'(PRS_SHORT_US);
    sel_b = lfsr[0] ^ half;

    // Control fields are held steady while the sequencer is busy; the delay length stays writable.
    if (wr_ctrl && state == fq_pkg::S_IDLE)
    begin
      next_gate_sel = (pwdata[fq_pkg::CTRL_GSEL +: 3] > fq_pkg::GSEL_MAX)
                    ? fq_pkg::GSEL_MAX : pwdata[fq_pkg::CTRL_GSEL +: 3];
      next_long_prs = pwdata[fq_pkg::CTRL_LONG];
      next_direct   = pwdata[fq_pkg::CTRL_DIRECT];
    end
    if (wr_delay)
    begin
      next_delay_us = pwdata[21:0];
    end
    // The sweep owns the divider while it runs.
    if (wr_synth && state != fq_pkg::S_SWEEP)
    begin
      next_synth_n = legal_n(pwdata[12:0]);
    end

    case (state)
      fq_pkg::S_IDLE:
      begin
        // Commands are ignored unless the sequencer is idle.
        if (wr_ctrl && pwdata[fq_pkg::CTRL_SWEEP])
        begin
          next_state     = fq_pkg::S_SWEEP;
          next_us_cnt    = 22'h00_0000;
          next_sweep_hit = 1'b0;
        end
        else if (wr_ctrl && pwdata[fq_pkg::CTRL_GO])
        begin
          next_done   = 1'b0;
          next_cnt_a  = 32'h0000_0000;
          next_cnt_b  = 32'h0000_0000;
          next_us_cnt = 22'h00_0000;
          if (pwdata[fq_pkg::CTRL_PRS])
          begin
            next_state    = fq_pkg::S_PRS;
            next_lfsr     = fq_pkg::LFSR_SEED;
            next_half     = 1'b0;
            next_wide_lat = 1'b1;
          end
          else
          begin
            next_state = fq_pkg::S_GATE;
          end
        end
      end
      fq_pkg::S_GATE:
      begin
        if (count_edge)
        begin
          next_cnt_a = cnt_a + 32'h0000_0001;
        end
        if (tbs.tick_us)
        begin
          next_us_cnt = us_inc;
          if (us_inc >= decade_us(gate_sel))
          begin
            next_state  = fq_pkg::S_DELAY;
            next_us_cnt = 22'h00_0000;
          end
        end
      end
      fq_pkg::S_PRS:
      begin
        if (count_edge)
        begin
          if (sel_b)
          begin
            next_cnt_b = cnt_b + 32'h0000_0001;
          end
          else
          begin
            next_cnt_a = cnt_a + 32'h0000_0001;
          end
        end
        if (!pin_s2[2])
        begin
          next_wide_lat = 1'b0;
        end
        if (tbs.tick_us)
        begin
          next_half   = ~half;
          next_us_cnt = us_inc;
          if (half)
          begin
            next_lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
          end
          if (us_inc >= prs_len)
          begin
            next_state  = fq_pkg::S_DELAY;
            next_us_cnt = 22'h00_0000;
          end
        end
      end
      fq_pkg::S_DELAY:
      begin
        if (delay_us == 22'h00_0000)
        begin
          next_state = fq_pkg::S_IDLE;
          next_done  = 1'b1;
        end
        else if (tbs.tick_us)
        begin
          next_us_cnt = us_inc;
          if (us_inc >= delay_us)
          begin
            next_state = fq_pkg::S_IDLE;
            next_done  = 1'b1;
          end
        end
      end
      fq_pkg::S_SWEEP:
      begin
        if (pin_s2[1])
        begin
          next_state     = fq_pkg::S_IDLE;
          next_sweep_hit = 1'b1;
        end
        else if (tbs.tick_us)
        begin
          next_us_cnt = us_inc;
          if (us_inc >= 22'(SWEEP_STEP_US))
          begin
            next_us_cnt = 22'h00_0000;
            if (synth_n > fq_pkg::N_MIN)
            begin
              next_synth_n = synth_n - fq_pkg::N_STEP;
            end
            else
            begin
              next_state = fq_pkg::S_IDLE;
            end
          end
        end
      end
      default:
      begin
        next_state = fq_pkg::S_IDLE;
      end
    endcase
  end

  // Sequencer registers and the pin-facing outputs; all but offset_search_enable are taken
  // from the next state so they change in the same edge as the state.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state       <= fq_pkg::S_IDLE;
      gate_sel    <= 3'h0;
      long_prs    <= 1'b0;
      direct_path <= 1'b0;
      delay_us    <= fq_pkg::DELAY_RST;
      cnt_a       <= 32'h0000_0000;
      cnt_b       <= 32'h0000_0000;
      done        <= 1'b0;
      wide_lat    <= 1'b0;
      sweep_hit   <= 1'b0;
      us_cnt      <= 22'h00_0000;
      lfsr        <= fq_pkg::LFSR_SEED;
      half        <= 1'b0;
      synth_n     <= fq_pkg::N_MAX;
      dir_gate    <= 1'b0;
      osc_sel     <= 1'b0;
      filter_wide <= 1'b1;
      offset_search_enable <= 1'b1;
    end
    else if (clk_en)
    begin
      state       <= next_state;
      gate_sel    <= next_gate_sel;
      long_prs    <= next_long_prs;
      direct_path <= next_direct;
      delay_us    <= next_delay_us;
      cnt_a       <= next_cnt_a;
      cnt_b       <= next_cnt_b;
      done        <= next_done;
      wide_lat    <= next_wide_lat;
      sweep_hit   <= next_sweep_hit;
      us_cnt      <= next_us_cnt;
      lfsr        <= next_lfsr;
      half        <= next_half;
      synth_n     <= next_synth_n;
      dir_gate    <= (next_state == fq_pkg::S_GATE);
      osc_sel     <= (next_state == fq_pkg::S_PRS) &
                     (next_lfsr[0] ^ next_half);
      filter_wide <= (next_state != fq_pkg::S_GATE) &&
                     (next_state != fq_pkg::S_PRS);
      offset_search_enable <= ~pin_s2[3];
    end
  end
endmodule // freq_counter_ctrl

// >>> fq_ctrl_asserts.sv
`timescale 1ns/10ps
module fq_ctrl_asserts (
  input wire logic        pclk,       // Clock.
  input wire logic        presetn,    // Reset, low.
  input wire logic        psel,       // Select.
  input wire logic        penable,    // Access.
  input wire logic        pwrite,     // Direction.
  input wire logic [7:0]  paddr,      // Address.
  input wire logic [31:0] pwdata,     // Write data.
  input wire logic        pready,     // Ready.
  input wire logic        diff_ok,    // Difference pin.
  input wire logic        if_narrow,  // Narrow pin.
  input wire logic        dir_gate,   // Gate.
  input wire logic        osc_sel,    // Chip select.
  input wire logic        filter_wide, // Wide filter.
  input wire logic        offset_search_enable, // Search.
  input wire logic [12:0] synth_n     // Divider.
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic wr;    // A write is taken.
  logic go_wr; // A plain start is taken.
  logic n_wr;  // A divider write is taken.
  assign wr    = psel && penable && pready && pwrite;
  assign go_wr = wr && paddr == 8'h00 && pwdata[0] && !pwdata[2];
  assign n_wr  = wr && paddr == 8'h10;
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable;
  endsequence
  AST_READY_WAIT: assert property (setup_s ##1 access_s |=> pready)
    else $error("ready late");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready held");
  AST_GATE_GO: assert property ($rose(dir_gate) |->
    $past(go_wr, 1) || $past(go_wr, 2) || $past(go_wr, 3))
    else $error("gate without start");
  AST_FILTER: assert property (dir_gate || osc_sel |-> !filter_wide)
    else $error("wide filter while counting");
  AST_CHIP_GATE: assert property (osc_sel |-> !dir_gate)
    else $error("chip during gate");
  AST_N_RANGE: assert property (synth_n[0] == 1'b0 &&
    synth_n >= 13'h1770 && synth_n <= 13'h1b58)
    else $error("divider out of range");
  AST_N_STEP: assert property ($changed(synth_n) |->
    13'($past(synth_n) - synth_n) == 13'h0002 ||
    $past(n_wr, 1) || $past(n_wr, 2) || $past(n_wr, 3))
    else $error("divider moved wrongly");
  AST_SRCH_OFF: assert property (diff_ok [*5] |-> !offset_search_enable)
    else $error("search still on");
  AST_NARROW: assert property (if_narrow [*5] |=>
    $stable(synth_n) || $past(n_wr, 1) || $past(n_wr, 2))
    else $error("sweep ran on");
endmodule // fq_ctrl_asserts

bind freq_counter_ctrl fq_ctrl_asserts u_chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .diff_ok(diff_ok),
  .if_narrow(if_narrow), .dir_gate(dir_gate), .osc_sel(osc_sel),
  .filter_wide(filter_wide), .synth_n(synth_n),
  .offset_search_enable(offset_search_enable));

// >>> fq_front_model.sv
`timescale 1ns/10ps
module fq_front_model (
  input  wire logic        pclk,      // System clock.
  input  wire logic [12:0] synth_n,   // Divider in use.
  input  wire logic [12:0] stop_n,    // Signal found at or below.
  output logic             count_in,  // Input count pin.
  output logic             if_narrow  // Narrow IF flag.
);
  logic [1:0] ph; // Half-period count.
  initial
  begin
    count_in  = 1'b0;
    if_narrow = 1'b0;
    ph        = 2'h0;
  end
  // The input runs free, one count per eight cycles, gate or not.
  always @(posedge pclk)
  begin
    ph       <= ph + 2'h1;
    count_in <= (ph == 2'h3) ? ~count_in : count_in;
  end
  // narrow flag
  // The IF falls in band once the sweep passes the signal.
  always @(posedge pclk)
    if_narrow <= (synth_n <= stop_n);
endmodule // fq_front_model

// >>> freq_counter_ctrl_tb.sv
`timescale 1ns/10ps
module freq_counter_ctrl_tb;
  logic        pclk, presetn, psel, penable, pwrite, err;
  logic        if_wide, diff_ok, pready, pslverr, count_in, clk_en, c1m;
  logic        if_narrow, dir_gate, osc_sel, filter_wide;
  logic        offset_search_enable, direct_path;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [12:0] synth_n, stop_n, nsav;
  int          mismatches, checks_done, w, hi, c1;
  typedef struct { logic [2:0] code; int lo; int hi; } row_t;
  // Gate code with the bounds of its width in cycles.
  row_t rows [4] = '{'{3'h0, 1, 5}, '{3'h1, 36, 41},
                     '{3'h2, 396, 401}, '{3'h3, 3996, 4001}};
  logic [31:0] nw [3] = '{32'h0000_1b17, 32'h0000_0064, 32'h0000_1f40};
  logic [31:0] ne [3] = '{32'h0000_1b16, 32'h0000_1770, 32'h0000_1b58};
  // Short counts keep the run brief.
  freq_counter_ctrl #(.US_CYCLES(4), .PRS_SHORT_US(20),
    .PRS_LONG_US(40), .SWEEP_STEP_US(2)) u_dut (.pclk(pclk),
    .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .count_in(count_in),
    .if_narrow(if_narrow), .if_wide(if_wide), .diff_ok(diff_ok),
    .dir_gate(dir_gate), .osc_sel(osc_sel), .filter_wide(filter_wide),
    .offset_search_enable(offset_search_enable),
    .direct_path(direct_path), .synth_n(synth_n), .clk_10m(),
    .clk_1m(c1m), .clk_500k(), .ref_50k());
  fq_front_model u_front (.pclk(pclk), .synth_n(synth_n),
    .stop_n(stop_n), .count_in(count_in), .if_narrow(if_narrow));
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // Counter B chip time (osc_sel high) is tallied here while a sequence runs.
  always @(posedge pclk)
    if (osc_sel === 1'b1) hi++;
  // Rising edges of the 1 MHz logic clock are tallied here.
  always @(posedge c1m)
    c1++;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One APB transfer; the request holds until ready is seen.
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // Poll status until the sequencer is idle.
  task automatic wait_idle();
    do
      apb(1'b0, 8'h04, 32'h0);
    while (rd[0] !== 1'b0);
  endtask
  task automatic wrap_up();
    $display("mismatches=%0d checks_done=%0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // A hang counts against the run.
  initial
  begin
    #400_000;
    mismatches++;
    wrap_up();
  end
  initial
  begin
    {presetn, psel, penable, pwrite, diff_ok} = 5'h00;
    clk_en = 1'b1;
    {paddr, pwdata, stop_n, if_wide} = 54'h1;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check({synth_n, filter_wide, offset_search_enable, dir_gate},
          32'h0000_dac6);
    apb(1'b0, 8'h14, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    check({err, rd[30:0]}, 32'h8000_0000);
    foreach (rows[i])
    begin
      apb(1'b1, 8'h00, {24'h0, 1'b1, rows[i].code, 4'h1});
      w = 0;
      wait (dir_gate === 1'b1);
      while (dir_gate === 1'b1)
      begin
        @(posedge pclk);
        w++;
      end
      check(32'(w >= rows[i].lo && w <= rows[i].hi), 32'h1);
      wait_idle();
      check(32'(rd[1]), 32'h1);
      check(32'(direct_path), 32'h1);
      apb(1'b0, 8'h08, 32'h0);
      check(32'(rd + 1 >= rows[i].lo / 8 && rd <= rows[i].hi / 8 + 1),
            32'h1);
    end
    // A code above six must clamp to the one second gate.
    apb(1'b1, 8'h00, 32'h0000_0070);
    apb(1'b0, 8'h00, 32'h0);
    check(rd, 32'h0000_0060);
    // manual mode: software fixes the divider itself.
    foreach (nw[i])
    begin
      apb(1'b1, 8'h10, nw[i]);
      apb(1'b0, 8'h10, 32'h0);
      check(rd, ne[i]);
    end
    // Short then long sequence; the second loses the wide flag.
    for (int l = 0; l < 2; l++)
    begin
      hi = 0;
      apb(1'b1, 8'h00, {28'h0, l[0], 3'h3});
      if (l == 1)
      begin
        repeat (20) @(posedge pclk);
        if_wide <= 1'b0;
        repeat (3) @(posedge pclk);
        if_wide <= 1'b1;
      end
      wait_idle();
      check(32'(rd[2]), 32'(l == 0));
      check(32'(hi + 4 >= (40 << l) && hi <= (40 << l) + 4), 32'h1);
    end
    stop_n <= 13'h1af4;
    apb(1'b1, 8'h00, 32'h0000_0004);
    wait_idle();
    check(32'(rd[4]), 32'h1);
    apb(1'b0, 8'h10, 32'h0);
    check(32'(rd == 32'h1af4 || rd == 32'h1af2), 32'h1);
    stop_n <= 13'h0;
    apb(1'b1, 8'h10, rd - 32'h2);
    apb(1'b1, 8'h00, 32'h0000_0004);
    // A low clock enable must freeze the running sweep.
    repeat (4) @(posedge pclk);
    clk_en <= 1'b0;
    @(posedge pclk);
    nsav = synth_n;
    repeat (20) @(posedge pclk);
    check(32'(synth_n), 32'(nsav));
    clk_en <= 1'b1;
    wait_idle();
    check(32'(rd[4]), 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    check(rd, 32'h0000_1770);
    diff_ok <= 1'b1;
    repeat (6) @(posedge pclk);
    check(32'(offset_search_enable), 32'h0);
    diff_ok <= 1'b0;
    repeat (6) @(posedge pclk);
    apb(1'b0, 8'h04, 32'h0);
    check(32'(rd[5]), 32'h1);
    // Four system clocks per microsecond give ten edges in forty.
    w = c1;
    repeat (40) @(posedge pclk);
    check(32'(c1 - w), 32'd10);
    wrap_up();
  end
endmodule // freq_counter_ctrl_tb
